// ---- hw/cbcd_decoder.v ----
// Configuration command decoder with AXI4-Lite access to the cyclic data images
`include "cbcd_regs.vh"
//
// Contract
// - Command 0x1 returns the extended status block; block field is zero.
// - Command 0x2 reads back block 1,2,3,5,6; 0xF restores defaults to working memory.
// - Command 0xA writes the named block; block 0xF saves to non-volatile memory.
// - Read-back uses only word zero; other output words are ignored.
// - Read-back places the block in the input image, laid out as its write.
// - Word values 0x8201, 0x8202, 0x8203, 0x8205 and 0x8206 are recognised as read-back requests.
// - Factory restore changes working memory only; save is needed separately.
// - Data block bit 0 selects little (0) or big (1) endian word order.
// - I/O bit 8 sets input polarity: 1 active with current flowing.
// - I/O bits 3..0 select each input's function.
// - Word zero bit 15 selects configuration mode; bits 14-12 and 7-4 zero.
// - Command from bits 11-8, block number from bits 3-0 of word zero.
// - Configuration data in command mode with drive enabled gives command error.
module cbcd_decoder (
    input wire CLK_SYS,
    input wire RST_B,
    input wire [7:0] S_AXI_AWADDR,
    input wire S_AXI_AWVALID,
    output wire S_AXI_AWREADY,
    input wire [31:0] S_AXI_WDATA,
    input wire [3:0] S_AXI_WSTRB,
    input wire S_AXI_WVALID,
    output wire S_AXI_WREADY,
    output reg [1:0] S_AXI_BRESP,
    output reg S_AXI_BVALID,
    input wire S_AXI_BREADY,
    input wire [7:0] S_AXI_ARADDR,
    input wire S_AXI_ARVALID,
    output wire S_AXI_ARREADY,
    output reg [31:0] S_AXI_RDATA,
    output reg [1:0] S_AXI_RRESP,
    output reg S_AXI_RVALID,
    input wire S_AXI_RREADY,
    input wire DRIVE_ENABLED,
    input wire [159:0] XSTAT_BLOCK,
    input wire [159:0] MOTOR_BLOCK,
    input wire [159:0] VEL_BLOCK,
    input wire [159:0] POS_BLOCK,
    output reg ENDIAN_BIG,
    output reg [`CBCD_N_INPUTS-1:0] INPUT_POLARITY,
    output reg [4*`CBCD_N_INPUTS-1:0] INPUT_FUNCTION,
    output reg FACTORY_RESTORE,
    output reg FLASH_SAVE,
    output reg [3:0] BLOCK_WRITE_SEL,
    output reg BLOCK_WRITE
);
    reg [15:0] out_img [0:9];
    reg [15:0] in_img [0:9];
    reg [15:0] data_cfg;
    reg [15:0] io_cfg [0:`CBCD_N_INPUTS-1];
    reg config_mode;
    reg cmd_error;
    reg cmd_pending;
    reg [15:0] cmd_count;
    reg aw_held, w_held;
    reg [7:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    integer i;
    wire [15:0] word0 = out_img[0];
    wire [3:0] cmd = word0[`CBCD_CMD_HI:`CBCD_CMD_LO];
    wire [3:0] blk = word0[`CBCD_BLK_HI:`CBCD_BLK_LO];
    wire mode_cfg = word0[`CBCD_MODE_BIT];
    wire rsv_ok = (word0 & `CBCD_RSV_MASK) == 16'h0000;
    wire blk_known = (blk == `CBCD_BLK_DATA) || (blk == `CBCD_BLK_IO) ||
                     (blk == `CBCD_BLK_MOTOR) || (blk == `CBCD_BLK_VEL) ||
                     (blk == `CBCD_BLK_POS);
    wire do_write = aw_held && w_held && !S_AXI_BVALID;
    wire [3:0] widx = aw_addr[5:2];
    wire in_out_img = (aw_addr < `CBCD_IN_BASE) && (widx < `CBCD_NWORDS);
    wire is_ctrl = aw_addr == `CBCD_CTRL_ADDR;
    wire [3:0] ridx = S_AXI_ARADDR[5:2];

    assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
    assign S_AXI_WREADY = !w_held && !S_AXI_BVALID;
    assign S_AXI_ARREADY = !S_AXI_RVALID;

    // Write channels and command issue
    always @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= `CBCD_AXI_OKAY;
            cmd_pending <= 1'b0;
            for (i = 0; i < 10; i = i + 1) begin
                out_img[i] <= 16'h0000;
            end
        end else begin
            cmd_pending <= 1'b0;
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_held <= 1'b1;
                aw_addr <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_held <= 1'b1;
                w_data <= S_AXI_WDATA;
                w_strb <= S_AXI_WSTRB;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= `CBCD_AXI_OKAY;
                if (in_out_img) begin
                    if (w_strb[0]) begin
                        out_img[widx][7:0] <= w_data[7:0];
                    end
                    if (w_strb[1]) begin
                        out_img[widx][15:8] <= w_data[15:8];
                    end
                end else if (is_ctrl) begin
                    cmd_pending <= w_data[0];
                end else if (!(aw_addr >= `CBCD_IN_BASE && aw_addr <= `CBCD_STAT_ADDR)) begin
                    S_AXI_BRESP <= `CBCD_AXI_SLVERR;
                end
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // Command interpreter
    always @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            data_cfg <= 16'h0000;
            for (i = 0; i < `CBCD_N_INPUTS; i = i + 1) begin
                io_cfg[i] <= `CBCD_DEF_IO;
            end
            for (i = 0; i < 10; i = i + 1) begin
                in_img[i] <= 16'h0000;
            end
            config_mode <= 1'b0;
            cmd_error <= 1'b0;
            cmd_count <= 16'h0000;
            FACTORY_RESTORE <= 1'b0;
            FLASH_SAVE <= 1'b0;
            BLOCK_WRITE <= 1'b0;
            BLOCK_WRITE_SEL <= 4'h0;
        end else begin
            FACTORY_RESTORE <= 1'b0;
            FLASH_SAVE <= 1'b0;
            BLOCK_WRITE <= 1'b0;
            if (cmd_pending) begin
                cmd_count <= cmd_count + 16'h0001;
                cmd_error <= 1'b0;
                if (mode_cfg && DRIVE_ENABLED && !config_mode) begin
                    // Rejected request keeps the unit in command mode
                    cmd_error <= 1'b1;
                    in_img[0] <= `CBCD_RESP_CMD_ERR;
                end else begin
                    config_mode <= mode_cfg;
                end
                if (!(mode_cfg && DRIVE_ENABLED && !config_mode) && mode_cfg && rsv_ok) begin
                    case (cmd)
                        `CBCD_CMD_XSTAT: begin
                            if (blk == 4'h0) begin
                                for (i = 0; i < 10; i = i + 1) begin
                                    in_img[i] <= XSTAT_BLOCK[16*i +: 16];
                                end
                            end
                        end
                        `CBCD_CMD_READ: begin
                            if (blk == `CBCD_BLK_SPECIAL) begin
                                data_cfg <= 16'h0000;
                                data_cfg[`CBCD_ENDIAN_BIT] <= `CBCD_DEF_ENDIAN;
                                for (i = 0; i < `CBCD_N_INPUTS; i = i + 1) begin
                                    io_cfg[i] <= `CBCD_DEF_IO;
                                end
                                FACTORY_RESTORE <= 1'b1;
                                in_img[0] <= word0;
                            end else if (blk_known) begin
                                in_img[0] <= word0 | 16'h0800;
                                for (i = 1; i < 10; i = i + 1) begin
                                    case (blk)
                                        `CBCD_BLK_DATA: in_img[i] <= (i == 1) ? data_cfg : 16'h0000;
                                        `CBCD_BLK_IO: in_img[i] <=
                                            (i <= `CBCD_N_INPUTS) ? io_cfg[i-1] : 16'h0000;
                                        `CBCD_BLK_MOTOR: in_img[i] <= MOTOR_BLOCK[16*i +: 16];
                                        `CBCD_BLK_VEL: in_img[i] <= VEL_BLOCK[16*i +: 16];
                                        `CBCD_BLK_POS: in_img[i] <= POS_BLOCK[16*i +: 16];
                                        default: in_img[i] <= 16'h0000;
                                    endcase
                                end
                            end
                        end
                        `CBCD_CMD_WRITE: begin
                            in_img[0] <= word0;
                            if (blk == `CBCD_BLK_SPECIAL) begin
                                FLASH_SAVE <= 1'b1;
                            end else if (blk_known) begin
                                BLOCK_WRITE <= 1'b1;
                                BLOCK_WRITE_SEL <= blk;
                                if (blk == `CBCD_BLK_DATA) begin
                                    data_cfg <= out_img[1];
                                end
                                if (blk == `CBCD_BLK_IO) begin
                                    for (i = 0; i < `CBCD_N_INPUTS; i = i + 1) begin
                                        io_cfg[i] <= out_img[i+1];
                                    end
                                end
                            end
                        end
                        default: begin
                            in_img[0] <= word0;
                        end
                    endcase
                end
            end
        end
    end

    // Configuration outputs
    always @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            ENDIAN_BIG <= `CBCD_DEF_ENDIAN;
            INPUT_POLARITY <= {`CBCD_N_INPUTS{1'b1}};
            INPUT_FUNCTION <= {4*`CBCD_N_INPUTS{1'b0}};
        end else begin
            ENDIAN_BIG <= data_cfg[`CBCD_ENDIAN_BIT];
            for (i = 0; i < `CBCD_N_INPUTS; i = i + 1) begin
                INPUT_POLARITY[i] <= io_cfg[i][`CBCD_POL_BIT];
                INPUT_FUNCTION[4*i +: 4] <= io_cfg[i][`CBCD_FUNC_HI:`CBCD_FUNC_LO];
            end
        end
    end

    // Read channel
    always @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= `CBCD_AXI_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP <= `CBCD_AXI_OKAY;
            S_AXI_RDATA <= 32'h0000_0000;
            if (S_AXI_ARADDR < `CBCD_IN_BASE && ridx < `CBCD_NWORDS) begin
                S_AXI_RDATA <= {16'h0000, out_img[ridx]};
            end else if (S_AXI_ARADDR >= `CBCD_IN_BASE && S_AXI_ARADDR < `CBCD_CTRL_ADDR
                         && ridx < `CBCD_NWORDS) begin
                S_AXI_RDATA <= {16'h0000, in_img[ridx]};
            end else if (S_AXI_ARADDR == `CBCD_CTRL_ADDR) begin
                S_AXI_RDATA <= 32'h0000_0000;
            end else if (S_AXI_ARADDR == `CBCD_STAT_ADDR) begin
                S_AXI_RDATA <= {cmd_count, 13'h0000, ENDIAN_BIG, cmd_error, config_mode};
            end else begin
                S_AXI_RRESP <= `CBCD_AXI_SLVERR;
            end
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end
endmodule

// ---- hw/cbcd_regs.vh ----
// Register offsets, field positions, commands and block numbers of the config decoder
`ifndef CBCD_REGS_VH
`define CBCD_REGS_VH
// Byte offsets on AXI4-Lite: output image words 0..9, input image words 0..9, status
`define CBCD_OUT_BASE 8'h00
`define CBCD_IN_BASE 8'h40
`define CBCD_CTRL_ADDR 8'h80
`define CBCD_STAT_ADDR 8'h84
`define CBCD_NWORDS 4'ha
// Configuration word zero fields
`define CBCD_MODE_BIT 15
`define CBCD_CMD_HI 11
`define CBCD_CMD_LO 8
`define CBCD_BLK_HI 3
`define CBCD_BLK_LO 0
`define CBCD_RSV_MASK 16'h70f0
// Commands
`define CBCD_CMD_NOP0 4'h0
`define CBCD_CMD_XSTAT 4'h1
`define CBCD_CMD_READ 4'h2
`define CBCD_CMD_NOP8 4'h8
`define CBCD_CMD_WRITE 4'ha
// Blocks
`define CBCD_BLK_DATA 4'h1
`define CBCD_BLK_IO 4'h2
`define CBCD_BLK_MOTOR 4'h3
`define CBCD_BLK_VEL 4'h5
`define CBCD_BLK_POS 4'h6
`define CBCD_BLK_SPECIAL 4'hf
// Block fields
`define CBCD_ENDIAN_BIT 0
`define CBCD_POL_BIT 8
`define CBCD_FUNC_HI 3
`define CBCD_FUNC_LO 0
`define CBCD_N_INPUTS 4
`define CBCD_IO_FIRST 4'h1
// Response tags in input word 0 bit 14 (error) and reset values
`define CBCD_ERR_BIT 14
`define CBCD_RESP_CMD_ERR 16'hc000
`define CBCD_DEF_ENDIAN 1'b0
`define CBCD_DEF_IO 16'h0100
`define CBCD_AXI_OKAY 2'b00
`define CBCD_AXI_SLVERR 2'b10
`endif

// ---- test/cbcd_checker.sv ----
// Assertions on the decoder's bus handshakes and configuration outputs
`include "cbcd_regs.vh"
module cbcd_checker (
    input wire CLK_SYS,
    input wire RST_B,
    input wire S_AXI_AWREADY,
    input wire S_AXI_WREADY,
    input wire S_AXI_BVALID,
    input wire S_AXI_BREADY,
    input wire S_AXI_ARREADY,
    input wire S_AXI_RVALID,
    input wire S_AXI_RREADY,
    input wire ENDIAN_BIG,
    input wire [`CBCD_N_INPUTS-1:0] INPUT_POLARITY,
    input wire [4*`CBCD_N_INPUTS-1:0] INPUT_FUNCTION,
    input wire FACTORY_RESTORE,
    input wire FLASH_SAVE
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);
    b_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
        else $error("bvalid dropped");
    r_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID)
        else $error("rvalid dropped");
    read_busy_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("read taken while busy");
    write_busy_a: assert property (S_AXI_BVALID |-> !(S_AXI_AWREADY || S_AXI_WREADY))
        else $error("write taken while busy");
    restore_pulse_a: assert property (FACTORY_RESTORE |=> !FACTORY_RESTORE)
        else $error("restore pulse too long");
    restore_value_a: assert property (FACTORY_RESTORE |-> ##[1:2] (!ENDIAN_BIG &&
        INPUT_POLARITY == 4'hf && INPUT_FUNCTION == 16'h0000)) else $error("no defaults");
    save_pulse_a: assert property (FLASH_SAVE |=> !FLASH_SAVE)
        else $error("save pulse too long");
    save_keep_a: assert property (FLASH_SAVE |=> ($stable(ENDIAN_BIG) &&
        $stable(INPUT_POLARITY))[*2]) else $error("save changed config");
    cover property (FACTORY_RESTORE);
    cover property (FLASH_SAVE);
    cover property (S_AXI_RVALID && !S_AXI_RREADY);
endmodule
bind cbcd_decoder cbcd_checker chk_i (.CLK_SYS, .RST_B, .S_AXI_AWREADY, .S_AXI_WREADY,
    .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARREADY, .S_AXI_RVALID, .S_AXI_RREADY,
    .ENDIAN_BIG, .INPUT_POLARITY, .INPUT_FUNCTION, .FACTORY_RESTORE, .FLASH_SAVE);

// ---- test/cbcd_host.sv ----
// Host controller model: AXI4-Lite master and its bus signals
interface cbcd_axi_if;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic awready, wready, bvalid, arready, rvalid;
endinterface
module cbcd_host (
    input wire logic clk,
    cbcd_axi_if bus
);
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge clk);
        bus.awaddr <= a;
        bus.wdata <= d;
        bus.awvalid <= 1'b1;
        bus.wvalid <= 1'b1;
        bus.bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge clk);
            if (!aw_done && bus.awready) begin
                aw_done = 1'b1;
                bus.awvalid <= 1'b0;
            end
            if (!w_done && bus.wready) begin
                w_done = 1'b1;
                bus.wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (!bus.bvalid);
        bus.bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        bus.araddr <= a;
        bus.arvalid <= 1'b1;
        bus.rready <= 1'b1;
        do @(posedge clk); while (!bus.arready);
        bus.arvalid <= 1'b0;
        do @(posedge clk); while (!bus.rvalid);
        d = bus.rdata;
        r = bus.rresp;
        bus.rready <= 1'b0;
    endtask
endmodule

// ---- test/tb_config_block_command_decoder.sv ----
// Self-checking bench of the configuration command decoder
`include "cbcd_regs.vh"
module tb_config_block_command_decoder;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic drive_en = 1'b0;
    wire endian_big;
    wire [3:0] pol;
    wire [15:0] func;
    wire [3:0] wsel;
    int n_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    function automatic logic [159:0] pat(input logic [3:0] b);
        for (int i = 0; i < 10; i++) pat[16*i+:16] = {b, 8'h00, 4'(i)};
    endfunction
    cbcd_axi_if bus ();
    cbcd_host host (.clk(clk), .bus(bus));
    cbcd_decoder dut (.CLK_SYS(clk), .RST_B(rst_b), .S_AXI_AWADDR(bus.awaddr),
        .S_AXI_AWVALID(bus.awvalid), .S_AXI_AWREADY(bus.awready), .S_AXI_WDATA(bus.wdata),
        .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(bus.wvalid), .S_AXI_WREADY(bus.wready),
        .S_AXI_BRESP(), .S_AXI_BVALID(bus.bvalid), .S_AXI_BREADY(bus.bready),
        .S_AXI_ARADDR(bus.araddr), .S_AXI_ARVALID(bus.arvalid), .S_AXI_ARREADY(bus.arready),
        .S_AXI_RDATA(bus.rdata), .S_AXI_RRESP(bus.rresp), .S_AXI_RVALID(bus.rvalid),
        .S_AXI_RREADY(bus.rready), .DRIVE_ENABLED(drive_en), .XSTAT_BLOCK(pat(4'h1)),
        .MOTOR_BLOCK(pat(4'h3)), .VEL_BLOCK(pat(4'h5)), .POS_BLOCK(pat(4'h6)),
        .ENDIAN_BIG(endian_big), .INPUT_POLARITY(pol), .INPUT_FUNCTION(func),
        .FACTORY_RESTORE(), .FLASH_SAVE(), .BLOCK_WRITE_SEL(wsel), .BLOCK_WRITE());
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        n_tests++;
        if (got !== want) begin
            n_errors++;
            $display("[FAIL] %0t got %h want %h", $time, got, want);
        end
    endtask
    task automatic rdchk(input logic [3:0] i, input logic [15:0] want);
        logic [31:0] d;
        logic [1:0] r;
        host.rd({2'b01, i, 2'b00}, d, r);
        chk(d, {16'h0, want});
    endtask
    task automatic cmd(input logic [15:0] w);
        host.wr(`CBCD_OUT_BASE, {16'h0, w});
        host.wr(`CBCD_CTRL_ADDR, 32'h1);
        repeat (4) @(posedge clk);
    endtask
    task automatic cfg(input logic [31:0] want);
        chk({11'h0, endian_big, pol, func}, want);
    endtask
    task automatic t_reset;
        logic [31:0] d;
        logic [1:0] r;
        cfg(32'h000f0000);
        host.rd(8'hfc, d, r);
        chk({30'h0, r}, {30'h0, `CBCD_AXI_SLVERR});
        host.rd(`CBCD_CTRL_ADDR, d, r);
        chk(d, 32'h0);
        $display("done reset");
    endtask
    task automatic t_cmd_error;
        drive_en <= 1'b1;
        host.wr(8'h04, 32'h1);
        cmd(16'h8a01);
        rdchk(4'h0, `CBCD_RESP_CMD_ERR);
        cfg(32'h000f0000);
        drive_en <= 1'b0;
        $display("done command error");
    endtask
    task automatic t_data;
        cmd(16'h8a01);
        cfg(32'h001f0000);
        chk({28'h0, wsel}, {28'h0, `CBCD_BLK_DATA});
        cmd(16'h8201);
        rdchk(4'h0, 16'h8a01);
        rdchk(4'h1, 16'h0001);
        $display("done data block");
    endtask
    task automatic t_io;
        host.wr(8'h04, 32'h0101);
        host.wr(8'h08, 32'h0002);
        host.wr(8'h0c, 32'h0100);
        host.wr(8'h10, 32'h0100);
        cmd(16'h8a02);
        cfg(32'h001d0021);
        cmd(16'h8202);
        rdchk(4'h1, 16'h0101);
        rdchk(4'h2, 16'h0002);
        rdchk(4'h4, 16'h0100);
        $display("done io block");
    endtask
    task automatic t_blocks;
        logic [3:0] b [4] = '{4'h1, 4'h3, 4'h5, 4'h6};
        for (int k = 0; k < 4; k++) begin
            cmd(k == 0 ? 16'h8100 : {12'h820, b[k]});
            for (int i = 1; i < 10; i++) rdchk(4'(i), {b[k], 8'h00, 4'(i)});
            if (k > 0) rdchk(4'h0, {12'h8a0, b[k]});
        end
        $display("done read blocks");
    endtask
    task automatic t_restore;
        cmd(16'h820f);
        cfg(32'h000f0000);
        cmd(16'h8a0f);
        cfg(32'h000f0000);
        $display("done restore");
    endtask
    task automatic t_reserved;
        logic [15:0] bad [6] = '{16'h8a11, 16'h9a01, 16'h8a12, 16'h8a04, 16'h8a0e, 16'h0a01};
        for (int k = 0; k < 22; k++) begin
            if (k != 1 && k != 2 && k != 10) begin
                cmd(k < 16 ? {4'h8, 4'(k), 8'h00} : bad[k-16]);
                cfg(32'h000f0000);
            end
        end
        $display("done reserved");
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            report_and_stop;
        end
    end
    initial begin
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        t_reset;
        t_cmd_error;
        t_data;
        t_io;
        t_blocks;
        t_restore;
        t_reserved;
        report_and_stop;
    end
endmodule
